// *** hw/gpio_freq_status_consts.svh ***
`ifndef GPIO_FREQ_STATUS_CONSTS_SVH
`define GPIO_FREQ_STATUS_CONSTS_SVH

// register indexes; byte address is four times the index
`define IDX_MAILBOX_A      8'h18
`define IDX_MAILBOX_B      8'h19
`define IDX_PIN_CFG        8'h1A
`define IDX_EDGE_COUNT     8'h1B
`define IDX_LINK_STATUS    8'h1C
`define IDX_IRQ_STATUS     8'h20
`define IDX_IRQ_MASK       8'h21
`define IDX_PIN_LEVEL      8'h22

// reset values
`define RST_MAILBOX_A      8'h00
`define RST_MAILBOX_B      8'h01
`define RST_PIN_CFG        8'h00
`define RST_IRQ_MASK       8'h00

// link status field positions
`define STS_DUAL_BIT       4
`define STS_AUDIO_BIT      3
`define STS_LOCK_BIT       0
`define STS_FIXED_ONES     8'h20

// interrupt status field positions
`define IRQ_DONE_BIT       0
`define IRQ_LOCK_LOST_BIT  1
`define IRQ_AUDIO_LOST_BIT 2

// timing
`define CLK_PERIOD_NS      8
`define OSC_PERIOD_NS      40
`define OSC_CYCLES         ((`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EDGE_COUNT_MAX     8'hFF

`endif

// *** hw/gpio_freq_status_pkg.sv ***
package gpio_freq_status_pkg;

    // pad mode encoded as {direction, enable}
    typedef enum logic [1:0] {
        PAD_FUNC  = 2'b00,
        PAD_DRIVE = 2'b01,
        PAD_TRI   = 2'b10,
        PAD_INPUT = 2'b11
    } pad_mode_e;

    typedef struct packed {
        logic global_out_value;
        logic reserved_6;
        logic global_direction;
        logic global_enable;
        logic pin_nine_out_value;
        logic reserved_2;
        logic pin_nine_direction;
        logic pin_nine_enable;
    } pin_cfg_s;

    typedef enum logic {
        CNT_IDLE = 1'b0,
        CNT_RUN  = 1'b1
    } cnt_state_e;

endpackage : gpio_freq_status_pkg

// *** hw/pad_pair_decode.sv ***
`timescale 1ns/10ps
module pad_pair_decode (
    input  wire logic                            direction_in,
    input  wire logic                            enable_in,
    output gpio_freq_status_pkg::pad_mode_e      mode_out
);
    always_comb begin
        case ({direction_in, enable_in})
            2'b00:   mode_out = gpio_freq_status_pkg::PAD_FUNC;
            2'b10:   mode_out = gpio_freq_status_pkg::PAD_TRI;
            2'b01:   mode_out = gpio_freq_status_pkg::PAD_DRIVE;
            2'b11:   mode_out = gpio_freq_status_pkg::PAD_INPUT;
            default: mode_out = gpio_freq_status_pkg::PAD_TRI;
        endcase
    end
endmodule : pad_pair_decode

// *** hw/freq_edge_counter.sv ***
`timescale 1ns/10ps
`include "gpio_freq_status_consts.svh"
module freq_edge_counter #(
    parameter int OSC_CYCLES = `OSC_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic [7:0] periods_in,
    input  wire logic       pix_clk_in,
    output logic      [7:0] count_out,
    output logic            busy_out,
    output logic            done_out
);
    localparam int OW = (OSC_CYCLES < 2) ? 1 : $clog2(OSC_CYCLES);

    generate
        if (OSC_CYCLES < 1) begin : g_bad_osc
            $error("freq_edge_counter: OSC_CYCLES must be at least 1");
        end
    endgenerate

    gpio_freq_status_pkg::cnt_state_e state_q;
    logic                             pix_s1_q;
    logic                             pix_s2_q;
    logic                             pix_s3_q;
    logic                             pix_rise;
    logic [OW-1:0]                    osc_q;
    logic [7:0]                       left_q;
    logic [7:0]                       count_q;
    logic                             done_q;
    logic                             osc_wrap;

    // pixel clock is sampled as a level; it must stay below half of clk_in
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pix_s1_q <= 1'b0;
            pix_s2_q <= 1'b0;
            pix_s3_q <= 1'b0;
        end else begin
            pix_s1_q <= pix_clk_in;
            pix_s2_q <= pix_s1_q;
            pix_s3_q <= pix_s2_q;
        end
    end

    assign pix_rise = pix_s2_q & ~pix_s3_q;
    assign osc_wrap = (osc_q == OW'(OSC_CYCLES - 1));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= gpio_freq_status_pkg::CNT_IDLE;
            osc_q   <= '0;
            left_q  <= 8'h00;
            count_q <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start_in) begin
                // restart drops any measurement in flight
                osc_q   <= '0;
                left_q  <= periods_in;
                count_q <= 8'h00;
                if (periods_in == 8'h00) begin
                    state_q <= gpio_freq_status_pkg::CNT_IDLE;
                    done_q  <= 1'b1;
                end else begin
                    state_q <= gpio_freq_status_pkg::CNT_RUN;
                end
            end else begin
                case (state_q)
                    gpio_freq_status_pkg::CNT_RUN: begin
                        if (pix_rise && count_q != `EDGE_COUNT_MAX) begin
                            count_q <= count_q + 8'h01;
                        end
                        if (osc_wrap) begin
                            osc_q  <= '0;
                            left_q <= left_q - 8'h01;
                            if (left_q == 8'h01) begin
                                state_q <= gpio_freq_status_pkg::CNT_IDLE;
                                done_q  <= 1'b1;
                            end
                        end else begin
                            osc_q <= osc_q + OW'(1);
                        end
                    end
                    default: begin
                        state_q <= gpio_freq_status_pkg::CNT_IDLE;
                    end
                endcase
            end
        end
    end

    assign count_out = count_q;
    assign busy_out  = (state_q == gpio_freq_status_pkg::CNT_RUN);
    assign done_out  = done_q;
endmodule : freq_edge_counter

// *** hw/gpio_freq_status_regs.sv ***
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "gpio_freq_status_consts.svh"
module gpio_freq_status_regs #(
    parameter int OSC_CYCLES = `OSC_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic             irq_out,
    input  wire logic        pix_clk_in,
    input  wire logic        dual_link_active_in,
    input  wire logic        audio_pll_locked_in,
    input  wire logic        cdr_lock_ch0_in,
    input  wire logic        cdr_lock_ch1_in,
    input  wire logic        remote_ctrl_in,
    input  wire logic        remote_value_in,
    input  wire logic        functional_data_in,
    input  wire logic        pin_nine_pad_in,
    output logic             pin_nine_pad_out,
    output logic             pin_nine_pad_oe_out
);
    logic [7:0]                         mailbox_a_q;
    logic [7:0]                         mailbox_b_q;
    gpio_freq_status_pkg::pin_cfg_s     cfg_q;
    logic [7:0]                         irq_status_q;
    logic [7:0]                         irq_mask_q;
    logic                               wait_q;
    logic [31:0]                        rdata_q;
    logic                               irq_q;
    logic                               pad_out_q;
    logic                               pad_oe_q;
    logic                               pad_level_q;
    logic                               dual_q;
    logic                               audio_q;
    logic                               lock_q;
    logic                               lock_d;
    logic                               wr_take;
    logic                               rd_take;
    logic                               start_count;
    logic [7:0]                         edge_count;
    logic                               count_busy;
    logic                               count_done;
    logic [7:0]                         status_view;
    logic [7:0]                         irq_events;
    logic [7:0]                         rd_mux;
    logic                               irq_status_rd;
    logic                               pad_out_d;
    logic                               pad_oe_d;
    gpio_freq_status_pkg::pad_mode_e    local_mode;
    gpio_freq_status_pkg::pad_mode_e    global_mode;

    // bus: one wait cycle, then the answer; effects happen on the acknowledging edge
    assign wr_take       = avs_write_in && !wait_q;
    assign rd_take       = avs_read_in && !wait_q;
    assign start_count   = wr_take && avs_byteenable_in[0]
                           && (avs_address_in == `IDX_EDGE_COUNT);
    assign irq_status_rd = rd_take && (avs_address_in == `IDX_IRQ_STATUS);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_q <= 1'b1;
        end else if (wait_q && (avs_read_in || avs_write_in)) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // register writes; reserved config bits store like the others
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mailbox_a_q <= `RST_MAILBOX_A;
            mailbox_b_q <= `RST_MAILBOX_B;
            cfg_q       <= `RST_PIN_CFG;
            irq_mask_q  <= `RST_IRQ_MASK;
        end else if (wr_take && avs_byteenable_in[0]) begin
            case (avs_address_in)
                `IDX_MAILBOX_A: mailbox_a_q <= avs_writedata_in[7:0];
                `IDX_MAILBOX_B: mailbox_b_q <= avs_writedata_in[7:0];
                `IDX_PIN_CFG:   cfg_q       <= avs_writedata_in[7:0];
                `IDX_IRQ_MASK:  irq_mask_q  <= avs_writedata_in[7:0];
                default:        mailbox_a_q <= mailbox_a_q;
            endcase
        end
    end

    // status inputs are taken as synchronous levels
    assign lock_d = cdr_lock_ch0_in && (!dual_link_active_in || cdr_lock_ch1_in);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dual_q      <= 1'b0;
            audio_q     <= 1'b0;
            lock_q      <= 1'b0;
            pad_level_q <= 1'b0;
        end else begin
            dual_q      <= dual_link_active_in;
            audio_q     <= audio_pll_locked_in;
            lock_q      <= lock_d;
            pad_level_q <= pin_nine_pad_in;
        end
    end

    always_comb begin
        status_view                 = `STS_FIXED_ONES;
        status_view[`STS_DUAL_BIT]  = dual_q;
        status_view[`STS_AUDIO_BIT] = audio_q;
        status_view[`STS_LOCK_BIT]  = lock_q;
    end

    // sticky events: measurement done, lock lost, audio lock lost
    always_comb begin
        irq_events                      = 8'h00;
        irq_events[`IRQ_DONE_BIT]       = count_done;
        irq_events[`IRQ_LOCK_LOST_BIT]  = lock_q && !lock_d;
        irq_events[`IRQ_AUDIO_LOST_BIT] = audio_q && !audio_pll_locked_in;
    end

    // a read clears the sticky bits, but an event on that same edge survives
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_status_q <= 8'h00;
        end else if (irq_status_rd) begin
            irq_status_q <= irq_events;
        end else begin
            irq_status_q <= irq_status_q | irq_events;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    always_comb begin
        case (avs_address_in)
            `IDX_MAILBOX_A:   rd_mux = mailbox_a_q;
            `IDX_MAILBOX_B:   rd_mux = mailbox_b_q;
            `IDX_PIN_CFG:     rd_mux = cfg_q;
            `IDX_EDGE_COUNT:  rd_mux = edge_count;
            `IDX_LINK_STATUS: rd_mux = status_view;
            `IDX_IRQ_STATUS:  rd_mux = irq_status_q;
            `IDX_IRQ_MASK:    rd_mux = irq_mask_q;
            `IDX_PIN_LEVEL:   rd_mux = {6'h00, count_busy, pad_level_q};
            default:          rd_mux = 8'h00;
        endcase
    end

    // read data is latched while waitrequest is still high, so it stands at the taking edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (wait_q && avs_read_in) begin
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    freq_edge_counter #(
        .OSC_CYCLES (OSC_CYCLES)
    ) u_counter (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (start_count),
        .periods_in (avs_writedata_in[7:0]),
        .pix_clk_in (pix_clk_in),
        .count_out  (edge_count),
        .busy_out   (count_busy),
        .done_out   (count_done)
    );

    pad_pair_decode u_local_decode (
        .direction_in (cfg_q.pin_nine_direction),
        .enable_in    (cfg_q.pin_nine_enable),
        .mode_out     (local_mode)
    );

    pad_pair_decode u_global_decode (
        .direction_in (cfg_q.global_direction),
        .enable_in    (cfg_q.global_enable),
        .mode_out     (global_mode)
    );

    // pin nine pad: own pair wins whenever it is not functional
    always_comb begin
        pad_out_d = 1'b0;
        pad_oe_d  = 1'b0;
        if (local_mode != gpio_freq_status_pkg::PAD_FUNC) begin
            case (local_mode)
                gpio_freq_status_pkg::PAD_DRIVE: begin
                    pad_oe_d  = 1'b1;
                    pad_out_d = remote_ctrl_in ? remote_value_in
                                               : cfg_q.pin_nine_out_value;
                end
                default: begin
                    pad_oe_d = 1'b0;
                end
            endcase
        end else begin
            case (global_mode)
                gpio_freq_status_pkg::PAD_FUNC: begin
                    pad_oe_d  = 1'b1;
                    pad_out_d = functional_data_in;
                end
                gpio_freq_status_pkg::PAD_DRIVE: begin
                    pad_oe_d  = 1'b1;
                    pad_out_d = cfg_q.global_out_value;
                end
                default: begin
                    pad_oe_d = 1'b0;
                end
            endcase
        end
    end

    // registered pad drive costs one cycle of latency but keeps the pin glitch free
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_out_q <= 1'b0;
            pad_oe_q  <= 1'b0;
        end else begin
            pad_out_q <= pad_out_d;
            pad_oe_q  <= pad_oe_d;
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign irq_out             = irq_q;
    assign pin_nine_pad_out    = pad_out_q;
    assign pin_nine_pad_oe_out = pad_oe_q;
endmodule : gpio_freq_status_regs

// *** dv/gpio_freq_status_regs_checker.sv ***
`timescale 1ns/10ps
module gpio_freq_status_regs_checker #(
    parameter int OSC_CYCLES = 5
) (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        irq_out,
    input wire logic        pix_clk_in,
    input wire logic        dual_link_active_in,
    input wire logic        audio_pll_locked_in,
    input wire logic        cdr_lock_ch0_in,
    input wire logic        cdr_lock_ch1_in,
    input wire logic        remote_ctrl_in,
    input wire logic        remote_value_in,
    input wire logic        functional_data_in,
    input wire logic        pin_nine_pad_in,
    input wire logic        pin_nine_pad_out,
    input wire logic        pin_nine_pad_oe_out
);
    logic [7:0] cfg_q;
    logic [3:0] stat_q;
    logic [3:0] stat_c;
    logic [1:0] age_q;
    logic       lock_c;
    logic       st_rd;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    assign stat_c = {dual_link_active_in, audio_pll_locked_in, cdr_lock_ch0_in, cdr_lock_ch1_in};
    assign lock_c = dual_link_active_in ? (cdr_lock_ch0_in & cdr_lock_ch1_in) : cdr_lock_ch0_in;
    // status is only judged once its inputs sat still, since the design may register them
    assign st_rd  = avs_read_in && !avs_waitrequest_out && avs_address_in == 8'h1C
                    && age_q == 2'h3 && stat_c == stat_q;
    // shadow of the pin config, committed on the same edge as the register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q  <= 8'h00;
            stat_q <= 4'h0;
            age_q  <= 2'h0;
        end else begin
            if (avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h1A
                && avs_byteenable_in[0]) begin
                cfg_q <= avs_writedata_in[7:0];
            end
            stat_q <= stat_c;
            if (stat_c != stat_q) begin
                age_q <= 2'h0;
            end else if (age_q != 2'h3) begin
                age_q <= age_q + 2'h1;
            end
        end
    end
    property p_answer;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing off");
    property p_func;
        cfg_q[5:4] == 2'b00 && cfg_q[1:0] == 2'b00
        |=> pin_nine_pad_oe_out && pin_nine_pad_out == $past(functional_data_in);
    endproperty
    a_func: assert property (p_func) else $error("functional drive wrong");
    property p_glob_drive;
        cfg_q[5:4] == 2'b01 && cfg_q[1:0] == 2'b00
        |=> pin_nine_pad_oe_out && pin_nine_pad_out == $past(cfg_q[7]);
    endproperty
    a_glob_drive: assert property (p_glob_drive) else $error("global value not driven");
    property p_glob_off;
        cfg_q[5] && cfg_q[1:0] == 2'b00 |=> !pin_nine_pad_oe_out;
    endproperty
    a_glob_off: assert property (p_glob_off) else $error("global release ignored");
    property p_pin_off;
        cfg_q[1] |=> !pin_nine_pad_oe_out;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin release ignored");
    property p_pin_drive;
        cfg_q[1:0] == 2'b01 && !remote_ctrl_in
        |=> pin_nine_pad_oe_out && pin_nine_pad_out == $past(cfg_q[3]);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("local value not driven");
    property p_remote;
        cfg_q[1:0] == 2'b01 && remote_ctrl_in
        |=> pin_nine_pad_oe_out && pin_nine_pad_out == $past(remote_value_in);
    endproperty
    a_remote: assert property (p_remote) else $error("remote value not driven");
    property p_dual;
        st_rd |-> avs_readdata_out[7:4] == {3'b001, dual_link_active_in};
    endproperty
    a_dual: assert property (p_dual) else $error("dual link status wrong");
    property p_audio;
        st_rd |-> avs_readdata_out[3:1] == {audio_pll_locked_in, 2'b00};
    endproperty
    a_audio: assert property (p_audio) else $error("audio lock status wrong");
    property p_lock;
        st_rd |-> avs_readdata_out[0] == lock_c;
    endproperty
    a_lock: assert property (p_lock) else $error("lock status wrong");
endmodule : gpio_freq_status_regs_checker

bind gpio_freq_status_regs gpio_freq_status_regs_checker #(.OSC_CYCLES(OSC_CYCLES)) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .pix_clk_in(pix_clk_in),
    .dual_link_active_in(dual_link_active_in), .audio_pll_locked_in(audio_pll_locked_in),
    .cdr_lock_ch0_in(cdr_lock_ch0_in), .cdr_lock_ch1_in(cdr_lock_ch1_in),
    .remote_ctrl_in(remote_ctrl_in), .remote_value_in(remote_value_in),
    .functional_data_in(functional_data_in), .pin_nine_pad_in(pin_nine_pad_in),
    .pin_nine_pad_out(pin_nine_pad_out), .pin_nine_pad_oe_out(pin_nine_pad_oe_out)
);

// *** dv/gpio_freq_status_regs_tb_top.sv ***
`timescale 1ns/10ps
module gpio_freq_status_regs_tb_top;
    localparam int OSC = 4;
    typedef struct packed {
        logic [7:0] cfg;
        logic       rc;
        logic       rv;
        logic       fd;
        logic       oe;
        logic       out;
    } pad_row_s;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        irq_out;
    logic        pix_clk_in = 1'b0;
    logic        dual = 1'b0;
    logic        audio = 1'b0;
    logic        ch0 = 1'b0;
    logic        ch1 = 1'b0;
    logic        rc = 1'b0;
    logic        rv = 1'b0;
    logic        fd = 1'b0;
    logic        pad_in = 1'b0;
    logic        pin_nine_pad_out;
    logic        pin_nine_pad_oe_out;
    logic [1:0]  pix_ph = 2'h0;
    logic [31:0] rd_val;
    int          num_errors = 0;
    int          samples_checked = 0;
    // cfg, remote ctrl, remote value, functional data, expected oe, expected out
    pad_row_s rows [13] = '{{8'h00, 5'b00111}, {8'h00, 5'b00010}, {8'h90, 5'b00011},
        {8'h10, 5'b00110}, {8'h20, 5'b00100}, {8'h30, 5'b00100}, {8'h39, 5'b00011},
        {8'h31, 5'b00110}, {8'h91, 5'b11011}, {8'h99, 5'b10110}, {8'h12, 5'b00100},
        {8'h13, 5'b00000}, {8'h02, 5'b00100}};
    // {dual, audio, ch0, ch1} then expected status byte
    logic [11:0] st [4] = '{12'hE38, 12'hF39, 12'h221, 12'h528};

    gpio_freq_status_regs #(.OSC_CYCLES(OSC)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .irq_out(irq_out), .pix_clk_in(pix_clk_in), .dual_link_active_in(dual),
        .audio_pll_locked_in(audio), .cdr_lock_ch0_in(ch0), .cdr_lock_ch1_in(ch1),
        .remote_ctrl_in(rc), .remote_value_in(rv), .functional_data_in(fd),
        .pin_nine_pad_in(pad_in), .pin_nine_pad_out(pin_nine_pad_out),
        .pin_nine_pad_oe_out(pin_nine_pad_oe_out)
    );

    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // one pixel edge every three cycles keeps it below half the system clock
    always @(posedge clk_in) begin
        pix_ph <= (pix_ph == 2'h2) ? 2'h0 : pix_ph + 2'h1;
        pix_clk_in <= (pix_ph == 2'h2);
    end

    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_pad(input logic oe, input logic out);
        check("pad_oe", {31'h0, oe}, {31'h0, pin_nine_pad_oe_out});
        if (oe) check("pad_out", {31'h0, out}, {31'h0, pin_nine_pad_out});
    endtask : check_pad

    // held until waitrequest is seen low at a rising edge; a stuck bus counts as a mismatch
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= {24'h0, d};
        avs_byteenable_in <= be;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        if (n >= 40) num_errors++;
        // read data taken at the acknowledging edge, request dropped right after it
        rd_val = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'h1);
        check($sformatf("reg_%h", a), {24'h0, e}, rd_val);
    endtask : rd

    task automatic measure(input logic [7:0] n_per, input logic [7:0] lo, input logic [7:0] hi);
        int n;
        n = 0;
        wr(8'h1B, n_per);
        while (irq_out !== 1'b1 && n < 1500) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 1500) num_errors++;
        bus(1'b0, 8'h1B, 8'h00, 4'h1);
        check("edge_count_band", 32'h1, {31'h0, rd_val[7:0] >= lo && rd_val[7:0] <= hi});
        rd(8'h1B, rd_val[7:0]);
        rd(8'h20, 8'h01);
    endtask : measure

    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            @(posedge clk_in);
            rc <= rows[i].rc;
            rv <= rows[i].rv;
            fd <= rows[i].fd;
            wr(8'h1A, rows[i].cfg);
            repeat (2) @(posedge clk_in);
            @(negedge clk_in);
            check_pad(rows[i].oe, rows[i].out);
            rd(8'h1A, rows[i].cfg);
        end
        wr(8'h18, 8'h77);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        check_pad(1'b0, 1'b0);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(8'h18, 8'h00);
        rd(8'h19, 8'h01);
        rd(8'h1A, 8'h00);
        rd(8'h1B, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        check_pad(1'b1, fd);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        bus(1'b1, 8'h18, 8'hEE, 4'h0);
        rd(8'h18, 8'h00);
        wr(8'h18, 8'hA5);
        wr(8'h19, 8'h5A);
        rd(8'h18, 8'hA5);
        rd(8'h19, 8'h5A);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            {dual, audio, ch0, ch1} <= st[i][11:8];
            repeat (4) @(posedge clk_in);
            rd(8'h1C, st[i][7:0]);
        end
        rd(8'h20, 8'h06);
        rd(8'h20, 8'h00);
        check("irq_masked", 32'h0, {31'h0, irq_out});
        wr(8'h21, 8'h07);
        @(posedge clk_in);
        ch0 <= 1'b1;
        repeat (3) @(posedge clk_in);
        ch0 <= 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        check("irq_raised", 32'h1, {31'h0, irq_out});
        rd(8'h20, 8'h02);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        check("irq_cleared", 32'h0, {31'h0, irq_out});
        wr(8'h21, 8'h01);
        pad_in <= 1'b1;
        measure(8'h1E, 8'h27, 8'h29);
        measure(8'hFF, 8'hFF, 8'hFF);
        measure(8'h00, 8'h00, 8'h00);
        rd(8'h22, 8'h01);
        final_report();
    end
endmodule : gpio_freq_status_regs_tb_top
